//--- sensor_sample_fifo_bench.sv
// Self-checking bench for the sensor sample buffer.
`timescale 1ns/1ps
`include "ssf_defs.vh"
module sensor_sample_fifo_bench;
	logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [7:0]  PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000, PRDATA;
	logic        PREADY, PSLVERR, SAMPLE_VALID = 1'b0, ACQ_REQ, ENTRIES_AVAIL, LEVEL_REACHED, OVERFLOW;
	logic [11:0] SAMPLE_X = 12'h000, SAMPLE_Y = 12'h000, SAMPLE_Z = 12'h000, SAMPLE_TEMP = 12'h000;
	logic        trig_go = 1'b0, trig_pin, temp = 1'b0, ovf = 1'b0, act = 1'b0, hit = 1'b0;
	logic [15:0] q[$];
	logic [32:0] expq[$];
	logic [1:0]  mode = 2'h0;
	logic [8:0]  wm = 9'h080;
	logic [31:0] seed = 32'h0000_AD3D;
	int          num_errors = 0, n_tests = 0;
	ssf_top i_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
		.PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_VALID(SAMPLE_VALID),
		.SAMPLE_X(SAMPLE_X), .SAMPLE_Y(SAMPLE_Y), .SAMPLE_Z(SAMPLE_Z), .SAMPLE_TEMP(SAMPLE_TEMP),
		.ACTIVITY_EVENT(act), .SECOND_INTERRUPT_PIN(trig_pin), .ACQ_REQ(ACQ_REQ),
		.ENTRIES_AVAIL(ENTRIES_AVAIL), .LEVEL_REACHED(LEVEL_REACHED), .OVERFLOW(OVERFLOW));
	ssf_trig_src i_src (.go(trig_go), .pin(trig_pin));
	always #5 CLK = ~CLK;
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		PSEL <= 1'b1;
		PADDR <= a;
		PWRITE <= w;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		do @(posedge CLK); while (PREADY !== 1'b1);
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
		expq.push_back({err, e});
		xfer(a, 1'b0, 32'h0000_0000);
	endtask
	always @(posedge CLK) begin
		if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
			chk("read", {PSLVERR, PRDATA}, expq.pop_front());
	end
	function void put(input logic [15:0] e);
		if (mode == `SSF_MODE_OFF)
			return;
		if (mode == `SSF_MODE_TRIG) begin
			if (hit && q.size() == 512)
				return;
			if (!hit && q.size() != 0 && q.size() >= wm)
				void'(q.pop_front());
		end else if (q.size() == 512) begin
			ovf = 1'b1;
			if (mode != `SSF_MODE_STREAM)
				return;
			void'(q.pop_front());
		end
		q.push_back(e);
	endfunction
	task set_in(input logic trig);
		logic [11:0] v[4];
		logic [31:0] r;
		int i;
		for (i = 0; i < 4; i++) begin
			r = rnd();
			v[i] = r[11:0];
		end
		SAMPLE_X <= v[0];
		SAMPLE_Y <= v[1];
		SAMPLE_Z <= v[2];
		SAMPLE_TEMP <= v[3];
		if (trig) begin
			trig_go <= 1'b1;
			for (i = 0; i < 40 && ACQ_REQ !== 1'b1; i++) @(posedge CLK);
			chk("acq", {32'h0000_0000, ACQ_REQ}, 33'h0_0000_0001);
			trig_go <= 1'b0;
		end else begin
			SAMPLE_VALID <= 1'b1;
			@(posedge CLK);
			SAMPLE_VALID <= 1'b0;
		end
		for (i = 0; i < (temp ? 4 : 3); i++)
			put({i[1:0], {2{v[i][11]}}, v[i]});
		repeat (8) @(posedge CLK);
	endtask
	task pop();
		logic [15:0] e;
		e = 16'h0000;
		if (q.size() > 0) begin
			e = q.pop_front();
			ovf = 1'b0;
		end
		rd(`SSF_OFF_DATA, {24'h00_0000, e[7:0]});
		rd(`SSF_OFF_DATA, {24'h00_0000, e[15:8]});
	endtask
	task status();
		logic [9:0] c;
		logic [3:0] f;
		c = 10'(q.size());
		f = {ovf, mode != 2'h0 && {1'b0, wm} <= c, c != 10'h000, 1'b0};
		rd(`SSF_OFF_STATUS, {6'h00, c, temp ? `SSF_SETS_4AX : `SSF_SETS_3AX, 4'h0, f});
		chk("flags", {30'h0000_0000, OVERFLOW, LEVEL_REACHED, ENTRIES_AVAIL}, {30'h0000_0000, f[3:1]});
	endtask
	task cfg(input logic [1:0] m, input logic t, input logic [8:0] w, input logic g);
		mode = m;
		temp = t;
		wm = w;
		if (m == `SSF_MODE_OFF) begin
			q.delete();
			ovf = 1'b0;
		end
		xfer(`SSF_OFF_WMARK, 1'b1, {24'h00_0000, w[7:0]});
		xfer(`SSF_OFF_FILTER, 1'b1, {28'h000_0000, g, 3'h0});
		xfer(`SSF_OFF_CTRL, 1'b1, {28'h000_0000, w[8], t, m});
		rd(`SSF_OFF_CTRL, {28'h000_0000, w[8], t, m});
	endtask
	initial begin
		repeat (16) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd(`SSF_OFF_CTRL, {28'h000_0000, `SSF_RST_CTRL});
		rd(`SSF_OFF_WMARK, {24'h00_0000, `SSF_RST_WMARK});
		rd(`SSF_OFF_FILTER, {24'h00_0000, `SSF_RST_FILTER});
		rd(8'h20, 32'h0000_0000, 1'b1);
		xfer(`SSF_OFF_STATUS, 1'b1, 32'hFFFF_FFFF);
		status();
		cfg(`SSF_MODE_OLDEST, 1'b0, 9'h1F0, 1'b0);
		repeat (172) set_in(1'b0);
		status();
		pop();
		set_in(1'b0);
		status();
		repeat (513) pop();
		status();
		cfg(`SSF_MODE_STREAM, 1'b1, 9'h008, 1'b0);
		repeat (130) set_in(1'b0);
		status();
		repeat (3) pop();
		status();
		cfg(`SSF_MODE_OFF, 1'b0, 9'h003, 1'b0);
		set_in(1'b0);
		status();
		cfg(`SSF_MODE_STREAM, 1'b0, 9'h003, 1'b1);
		repeat (2) set_in(1'b1);
		repeat (4) pop();
		status();
		repeat (3) pop();
		cfg(`SSF_MODE_TRIG, 1'b0, 9'h004, 1'b0);
		repeat (3) set_in(1'b0);
		status();
		act <= 1'b1;
		hit = 1'b1;
		@(posedge CLK);
		act <= 1'b0;
		repeat (172) set_in(1'b0);
		status();
		repeat (4) pop();
		wrap_up();
	end
	initial begin
		repeat (30000) @(posedge CLK);
		num_errors++;
		wrap_up();
	end
endmodule // sensor_sample_fifo_bench

//--- ssf_defs.vh
// Constants shared by the sensor sample buffer files.
`ifndef SSF_DEFS_VH
`define SSF_DEFS_VH

`define SSF_AW            8
`define SSF_DEPTH_W       9
`define SSF_CNT_W         10
`define SSF_DEPTH         10'h0200
`define SSF_SETS_3AX      8'hAA
`define SSF_SETS_4AX      8'h80

`define SSF_OFF_CTRL      8'h00
`define SSF_OFF_WMARK     8'h04
`define SSF_OFF_FILTER    8'h08
`define SSF_OFF_STATUS    8'h0C
`define SSF_OFF_DATA      8'h10

`define SSF_CTRL_MODE_HI  1
`define SSF_CTRL_MODE_LO  0
`define SSF_CTRL_TEMP     2
`define SSF_CTRL_WM_HI    3
`define SSF_FILT_EXT_TRIG 3
`define SSF_ST_AVAIL      1
`define SSF_ST_LEVEL      2
`define SSF_ST_OVF        3
`define SSF_ST_SETS_HI    15
`define SSF_ST_SETS_LO    8
`define SSF_ST_CNT_HI     25
`define SSF_ST_CNT_LO     16

`define SSF_RST_CTRL      4'h0
`define SSF_RST_WMARK     8'h80
`define SSF_RST_FILTER    8'h00

`define SSF_MODE_OFF      2'h0
`define SSF_MODE_OLDEST   2'h1
`define SSF_MODE_STREAM   2'h2
`define SSF_MODE_TRIG     2'h3

`define SSF_TAG_X         2'h0
`define SSF_TAG_Y         2'h1
`define SSF_TAG_Z         2'h2
`define SSF_TAG_T         2'h3

`define SSF_BYTE_EMPTY    8'h00

`endif

//--- ssf_mem.v
// Entry storage array of the sample buffer.
`timescale 1ns/1ps
`include "ssf_defs.vh"

module ssf_mem (
	input  wire                    clk,
	input  wire                    we,
	input  wire [`SSF_DEPTH_W-1:0] waddr,
	input  wire [15:0]             wdata,
	input  wire [`SSF_DEPTH_W-1:0] raddr,
	output wire [15:0]             rdata
);
	reg [15:0] mem [0:`SSF_DEPTH-1];

	always @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read is combinational so the head entry is visible the cycle after it is written.
	assign rdata = mem[raddr];

endmodule // ssf_mem

//--- ssf_properties.sv
// Port-level assertions for the sensor sample buffer.
`timescale 1ns/1ps
module ssf_properties (
	input logic        CLK,
	input logic        RST,
	input logic        PSEL,
	input logic        PENABLE,
	input logic        PWRITE,
	input logic [7:0]  PADDR,
	input logic [31:0] PWDATA,
	input logic [31:0] PRDATA,
	input logic        PREADY,
	input logic        PSLVERR,
	input logic        SECOND_INTERRUPT_PIN,
	input logic        ACQ_REQ,
	input logic        ENTRIES_AVAIL,
	input logic        OVERFLOW
);
	logic [3:0] age_r;
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	// Saturating, so a long idle pin never wraps into a false recent edge.
	always @(posedge CLK) begin
		if (RST)
			age_r <= 4'hF;
		else if (SECOND_INTERRUPT_PIN)
			age_r <= 4'h0;
		else if (age_r != 4'hF)
			age_r <= age_r + 4'h1;
	end
	sequence s_setup;
		PSEL && !PENABLE;
	endsequence
	sequence s_off_write;
		PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[1:0] == 2'h0;
	endsequence
	a_ready_next: assert property (s_setup |=> PREADY)
		else $error("no ready after setup");
	a_ready_cause: assert property (PREADY |-> $past(PSEL) && !$past(PENABLE))
		else $error("ready without setup");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held");
	a_err_unmapped: assert property (PSEL && !PENABLE && PADDR[7:2] > 6'h04 |=> PSLVERR && PRDATA == 32'h0000_0000)
		else $error("unmapped not refused");
	a_ok_mapped: assert property (PSEL && !PENABLE && PADDR <= 8'h10 && PADDR[1:0] == 2'h0 |=> !PSLVERR)
		else $error("mapped refused");
	a_acq_pulse: assert property (ACQ_REQ |=> !ACQ_REQ)
		else $error("acquire held");
	a_acq_cause: assert property (ACQ_REQ |-> age_r < 4'h8)
		else $error("acquire without pin");
	a_off_clears: assert property (s_off_write |=> ##1 !ENTRIES_AVAIL && !OVERFLOW)
		else $error("disable left flags");
endmodule // ssf_properties

bind ssf_top ssf_properties i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.SECOND_INTERRUPT_PIN(SECOND_INTERRUPT_PIN), .ACQ_REQ(ACQ_REQ), .ENTRIES_AVAIL(ENTRIES_AVAIL),
	.OVERFLOW(OVERFLOW));

//--- ssf_top.v
// Sensor sample buffer with APB register access and external sample trigger.
`timescale 1ns/1ps
`include "ssf_defs.vh"

// Functional notes
// - Buffer holds 512 entries, axis and temperature.
// - Capacity is 170 or 128 sets.
// - Mode 00 stores nothing, clears buffer.
// - Mode 01 fills, stops, refills as read.
// - Mode 10 drops oldest entry when full.
// - Stream mode raises level at watermark count.
// - Mode 11 keeps watermark entries before event.
// - Flags for available, level reached, overflow.
// - Entry read low byte first, then high.
// - Twelve data bits, two sign, two tag.
// - Tags: 00 x, 01 y, 10 z, 11 temperature.
// - Bytes read past empty return zero.
// - Set written x, y, z, then temperature.
// - Auxiliary converter results never enter buffer.
// - Partial set stored when space runs short.
// - Each entry read frees exactly one entry.
// - Trigger enable paces sets from trigger pin.
// - Level flag while count at least watermark, in modes 01, 10 and 11 only.
// - Overflow on loss in modes 01 and 10, not 11, cleared by read, disable.
// - Available flag while any entry held.
module ssf_top (
	input  wire                  CLK,
	input  wire                  RST,
	input  wire                  PSEL,
	input  wire                  PENABLE,
	input  wire                  PWRITE,
	input  wire [`SSF_AW-1:0]    PADDR,
	input  wire [31:0]           PWDATA,
	output reg  [31:0]           PRDATA,
	output reg                   PREADY,
	output reg                   PSLVERR,
	input  wire                  SAMPLE_VALID,
	input  wire [11:0]           SAMPLE_X,
	input  wire [11:0]           SAMPLE_Y,
	input  wire [11:0]           SAMPLE_Z,
	input  wire [11:0]           SAMPLE_TEMP,
	input  wire                  ACTIVITY_EVENT,
	input  wire                  SECOND_INTERRUPT_PIN,
	output reg                   ACQ_REQ,
	output reg                   ENTRIES_AVAIL,
	output reg                   LEVEL_REACHED,
	output reg                   OVERFLOW
);
	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_X    = 5'h02;
	localparam [4:0] ST_Y    = 5'h04;
	localparam [4:0] ST_Z    = 5'h08;
	localparam [4:0] ST_T    = 5'h10;

	function ssf_hit;
		input [`SSF_AW-1:0] addr;
		input [`SSF_AW-1:0] off;
		begin
			ssf_hit = (addr[`SSF_AW-1:2] == off[`SSF_AW-1:2]);
		end
	endfunction

	function [15:0] ssf_entry;
		input [1:0]  tag;
		input [11:0] val;
		begin
			ssf_entry = {tag, val[11], val[11], val};
		end
	endfunction

	reg  [1:0]              mode_r;
	reg                     temp_en_r;
	reg                     wm_hi_r;
	reg  [7:0]              wm_lo_r;
	reg                     ext_en_r;
	reg  [`SSF_DEPTH_W-1:0] wr_ptr_r;
	reg  [`SSF_DEPTH_W-1:0] rd_ptr_r;
	reg  [`SSF_CNT_W-1:0]   cnt_r;
	reg                     ovf_r;
	reg                     trig_hit_r;
	reg                     phase_r;
	reg                     lo_valid_r;
	reg  [4:0]              st_r;
	reg                     set_temp_r;
	reg  [11:0]             x_r;
	reg  [11:0]             y_r;
	reg  [11:0]             z_r;
	reg  [11:0]             t_r;

	reg  [`SSF_DEPTH_W-1:0] wr_ptr_nxt;
	reg  [`SSF_DEPTH_W-1:0] rd_ptr_nxt;
	reg  [`SSF_CNT_W-1:0]   cnt_nxt;
	reg                     ovf_nxt;
	reg                     do_wr;
	reg                     drop_old;
	reg  [15:0]             wr_data;
	reg  [31:0]             rd_word;
	reg                     rd_err;

	wire [15:0]             head;
	wire                    trig_rise;
	wire [`SSF_CNT_W-1:0]   wm = {1'b0, wm_hi_r, wm_lo_r};
	wire [3:0]              rst_ctrl = `SSF_RST_CTRL;
	wire [7:0]              rst_filt = `SSF_RST_FILTER;
	wire                    setup = PSEL & ~PENABLE;
	wire                    acc = PSEL & PENABLE & PREADY;
	wire                    acc_wr = acc & PWRITE;
	wire                    acc_data = acc & ~PWRITE & ssf_hit(PADDR, `SSF_OFF_DATA);
	wire                    pop = acc_data & phase_r & lo_valid_r;
	// Entry writing pauses through setup and access, so the head and count seen at setup are the ones popped.
	wire                    stall = setup | PREADY;
	wire                    wr_go = ~stall & ~st_r[0];
	wire                    full = (cnt_r == `SSF_DEPTH);
	wire                    start = (mode_r != `SSF_MODE_OFF) & (ext_en_r ? trig_rise : SAMPLE_VALID);

	ssf_mem u_mem (
		.clk   (CLK),
		.we    (do_wr),
		.waddr (wr_ptr_r),
		.wdata (wr_data),
		.raddr (rd_ptr_r),
		.rdata (head)
	);

	ssf_trig u_trig (
		.clk  (CLK),
		.rst  (RST),
		.pin  (SECOND_INTERRUPT_PIN),
		.rise (trig_rise)
	);

	// Auxiliary converter data has no input here at all, only axis and temperature.
	always @* begin
		case (st_r)
			ST_X:    wr_data = ssf_entry(`SSF_TAG_X, x_r);
			ST_Y:    wr_data = ssf_entry(`SSF_TAG_Y, y_r);
			ST_Z:    wr_data = ssf_entry(`SSF_TAG_Z, z_r);
			ST_T:    wr_data = ssf_entry(`SSF_TAG_T, t_r);
			default: wr_data = 16'h0000;
		endcase
	end

	always @* begin
		do_wr    = 1'b0;
		drop_old = 1'b0;
		ovf_nxt  = ovf_r & ~pop;
		case (mode_r)
			`SSF_MODE_OLDEST: begin
				do_wr = wr_go & ~full;
				if (wr_go & full) begin
					ovf_nxt = 1'b1;
				end
			end
			`SSF_MODE_STREAM: begin
				do_wr    = wr_go;
				drop_old = wr_go & full;
				if (wr_go & full) begin
					ovf_nxt = 1'b1;
				end
			end
			`SSF_MODE_TRIG: begin
				if (trig_hit_r) begin
					do_wr = wr_go & ~full;
				end else begin
					do_wr    = wr_go;
					drop_old = wr_go & (cnt_r != {`SSF_CNT_W{1'b0}}) & (cnt_r >= wm);
				end
			end
			default: begin
				ovf_nxt = 1'b0;
			end
		endcase
		wr_ptr_nxt = wr_ptr_r + {{(`SSF_DEPTH_W-1){1'b0}}, do_wr};
		rd_ptr_nxt = rd_ptr_r + {{(`SSF_DEPTH_W-1){1'b0}}, drop_old | pop};
		cnt_nxt    = cnt_r + {{(`SSF_CNT_W-1){1'b0}}, do_wr} - {{(`SSF_CNT_W-1){1'b0}}, drop_old}
		           - {{(`SSF_CNT_W-1){1'b0}}, pop};
		if (mode_r == `SSF_MODE_OFF) begin
			wr_ptr_nxt = {`SSF_DEPTH_W{1'b0}};
			rd_ptr_nxt = {`SSF_DEPTH_W{1'b0}};
			cnt_nxt    = {`SSF_CNT_W{1'b0}};
		end
	end

	always @* begin
		rd_word = 32'h0000_0000;
		rd_err  = 1'b0;
		if (ssf_hit(PADDR, `SSF_OFF_CTRL)) begin
			rd_word[`SSF_CTRL_MODE_HI:`SSF_CTRL_MODE_LO] = mode_r;
			rd_word[`SSF_CTRL_TEMP]                     = temp_en_r;
			rd_word[`SSF_CTRL_WM_HI]                    = wm_hi_r;
		end else if (ssf_hit(PADDR, `SSF_OFF_WMARK)) begin
			rd_word[7:0] = wm_lo_r;
		end else if (ssf_hit(PADDR, `SSF_OFF_FILTER)) begin
			rd_word[`SSF_FILT_EXT_TRIG] = ext_en_r;
		end else if (ssf_hit(PADDR, `SSF_OFF_STATUS)) begin
			rd_word[`SSF_ST_AVAIL]                      = ENTRIES_AVAIL;
			rd_word[`SSF_ST_LEVEL]                      = LEVEL_REACHED;
			rd_word[`SSF_ST_OVF]                        = ovf_r;
			rd_word[`SSF_ST_SETS_HI:`SSF_ST_SETS_LO]    = temp_en_r ? `SSF_SETS_4AX : `SSF_SETS_3AX;
			rd_word[`SSF_ST_CNT_HI:`SSF_ST_CNT_LO]      = cnt_r;
		end else if (ssf_hit(PADDR, `SSF_OFF_DATA)) begin
			// An empty buffer, or a high byte whose low byte came from nothing, reads as zero.
			if (!phase_r) begin
				rd_word[7:0] = (cnt_r != {`SSF_CNT_W{1'b0}}) ? head[7:0] : `SSF_BYTE_EMPTY;
			end else begin
				rd_word[7:0] = lo_valid_r ? head[15:8] : `SSF_BYTE_EMPTY;
			end
		end else begin
			rd_err = 1'b1;
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= setup;
			if (setup) begin
				PRDATA  <= PWRITE ? 32'h0000_0000 : rd_word;
				PSLVERR <= rd_err;
			end
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			mode_r    <= rst_ctrl[`SSF_CTRL_MODE_HI:`SSF_CTRL_MODE_LO];
			temp_en_r <= rst_ctrl[`SSF_CTRL_TEMP];
			wm_hi_r   <= rst_ctrl[`SSF_CTRL_WM_HI];
			wm_lo_r   <= `SSF_RST_WMARK;
			ext_en_r  <= rst_filt[`SSF_FILT_EXT_TRIG];
		end else if (acc_wr) begin
			if (ssf_hit(PADDR, `SSF_OFF_CTRL)) begin
				mode_r    <= PWDATA[`SSF_CTRL_MODE_HI:`SSF_CTRL_MODE_LO];
				temp_en_r <= PWDATA[`SSF_CTRL_TEMP];
				wm_hi_r   <= PWDATA[`SSF_CTRL_WM_HI];
			end
			if (ssf_hit(PADDR, `SSF_OFF_WMARK)) begin
				wm_lo_r <= PWDATA[7:0];
			end
			if (ssf_hit(PADDR, `SSF_OFF_FILTER)) begin
				ext_en_r <= PWDATA[`SSF_FILT_EXT_TRIG];
			end
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			phase_r    <= 1'b0;
			lo_valid_r <= 1'b0;
		end else if (acc_data) begin
			phase_r    <= ~phase_r;
			lo_valid_r <= ~phase_r & (cnt_r != {`SSF_CNT_W{1'b0}});
		end
	end

	always @(posedge CLK) begin
		if (RST) begin
			st_r       <= ST_IDLE;
			set_temp_r <= 1'b0;
			x_r        <= 12'h000;
			y_r        <= 12'h000;
			z_r        <= 12'h000;
			t_r        <= 12'h000;
			ACQ_REQ    <= 1'b0;
		end else begin
			ACQ_REQ <= ext_en_r & trig_rise;
			case (st_r)
				ST_IDLE: begin
					// A new set that arrives while the previous one is still being written is lost.
					if (start) begin
						x_r        <= SAMPLE_X;
						y_r        <= SAMPLE_Y;
						z_r        <= SAMPLE_Z;
						t_r        <= SAMPLE_TEMP;
						set_temp_r <= temp_en_r;
						st_r       <= ST_X;
					end
				end
				ST_X:    if (!stall) st_r <= ST_Y;
				ST_Y:    if (!stall) st_r <= ST_Z;
				ST_Z:    if (!stall) st_r <= set_temp_r ? ST_T : ST_IDLE;
				ST_T:    if (!stall) st_r <= ST_IDLE;
				default: st_r <= ST_IDLE;
			endcase
		end
	end

	// Each entry is judged alone against free space, so a set may be cut short.
	always @(posedge CLK) begin
		if (RST) begin
			wr_ptr_r      <= {`SSF_DEPTH_W{1'b0}};
			rd_ptr_r      <= {`SSF_DEPTH_W{1'b0}};
			cnt_r         <= {`SSF_CNT_W{1'b0}};
			ovf_r         <= 1'b0;
			trig_hit_r    <= 1'b0;
			ENTRIES_AVAIL <= 1'b0;
			LEVEL_REACHED <= 1'b0;
			OVERFLOW      <= 1'b0;
		end else begin
			wr_ptr_r      <= wr_ptr_nxt;
			rd_ptr_r      <= rd_ptr_nxt;
			cnt_r         <= cnt_nxt;
			ovf_r         <= ovf_nxt;
			trig_hit_r    <= (mode_r == `SSF_MODE_TRIG) & (trig_hit_r | ACTIVITY_EVENT);
			ENTRIES_AVAIL <= (cnt_nxt != {`SSF_CNT_W{1'b0}});
			LEVEL_REACHED <= (mode_r != `SSF_MODE_OFF) & (cnt_nxt >= wm);
			OVERFLOW      <= ovf_nxt;
		end
	end

endmodule // ssf_top

//--- ssf_trig.v
// Synchroniser and rising-edge detector for the sample trigger pin.
`timescale 1ns/1ps

module ssf_trig (
	input  wire clk,
	input  wire rst,
	input  wire pin,
	output reg  rise
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	always @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
			rise   <= 1'b0;
		end else begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
			// The pin idles low, so only a low-to-high step asks for a sample.
			rise   <= sync_r & ~last_r;
		end
	end

endmodule // ssf_trig

//--- ssf_trig_src.sv
// External trigger source that pulses the sample trigger pin.
`timescale 1ns/1ps
module ssf_trig_src (
	input  logic go,
	output logic pin
);
	logic lclk = 1'b0;
	// Own 80 ns clock, unrelated to the block clock.
	always #40 lclk = ~lclk;
	initial pin = 1'b0;
	always @(posedge lclk) begin
		pin <= go & ~pin;
	end
endmodule // ssf_trig_src
